// ### verilog/sector_protect_map.sv
// Sector protection map command core: erase, program and read of the 64-byte map,
// self-timed busy cycles, and the protection lookup used by array commands.
// Assumes prot_enabled and the query port come from logic on clk_sys; pins do not.
//
// Summary of operation
// - Erase starts only when select rises right after the last opcode bit.
// - Busy shows during erase; erase ends within the maximum erase time.
// - Erase sets every map byte to FF, all sectors protected.
// - Erase accepted whether global protection is on or off.
// - With protection on, protected sectors refuse array program or erase.
// - Sixty-four data bytes, first for sector 0 up to sector 63.
// - Select rising after data starts the program cycle; busy meanwhile.
// - Bytes not received before select rises are left undefined.
// - Write pointer wraps; byte 65 lands on location 0 again.
// - Program accepted whether global protection is on or off.
// - Program command overwrites the first SRAM data buffer.
// - After dummies, map bytes shift out from sector 0 to 63.
// - After 64 bytes, further clocks give undefined output.
// - Select rising ends the read and floats the output.
// - Sectors 1 to 63: FF protected, 00 unprotected, byte n for sector n.
// - Byte 0: bits 7,6 guard pages 0-7; bits 5,4 pages 8-127.
// - Write-protect asserted blocks map erase and program.
`timescale 1ns/1ps
module sector_protect_map
    import spm_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
    parameter int PROG_CYCLES  = PROG_CYCLES_DEF
) (
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    input  wire logic                cs_n,
    input  wire logic                sck,
    input  wire logic                si,
    input  wire logic                wp_n,
    input  wire logic                prot_enabled,
    input  wire logic [SECTOR_W-1:0] query_sector,
    input  wire logic [PAGE_W-1:0]   query_page,
    output logic                     so_out,
    output logic                     so_oe,
    output logic                     busy,
    output logic                     query_protected,
    output logic                     buf1_wr_en,
    output logic [SECTOR_W-1:0]      buf1_wr_addr,
    output logic [7:0]               buf1_wr_data
);

    localparam int TIMER_W = $clog2((ERASE_CYCLES > PROG_CYCLES ? ERASE_CYCLES : PROG_CYCLES) + 1);

    spi_byte_if lnk ();

    frame_state_t        state_reg;
    logic [1:0]          seq_cnt_reg;
    logic                erase_req_reg;
    logic                prog_req_reg;
    logic [SECTOR_W-1:0] wr_ptr_reg;
    logic [SECTOR_W:0]   rd_idx_reg;
    logic [7:0]          tx_byte_reg;
    logic [1:0]          wp_sync_reg;
    logic                job_prog_reg;
    logic [TIMER_W-1:0]  timer_reg;
    logic [7:0]          map_reg [MAP_BYTES];
    logic [7:0]          stage_reg [MAP_BYTES];
    logic                wp_clear;
    logic                job_done;
    logic [TIMER_W-1:0]  job_last;

    spi_link_frontend u_front (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .cs_n    (cs_n),
        .sck     (sck),
        .si      (si),
        .so_out  (so_out),
        .so_oe   (so_oe),
        .lnk     (lnk.front)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write-protect pin, active low
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wp_sync_reg <= 2'h3;
        end else begin
            wp_sync_reg <= {wp_sync_reg[0], wp_n};
        end
    end
    assign wp_clear = wp_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Frame decoder
    always_ff @(posedge clk_sys) begin
        if (!resetn || lnk.frame_end) begin
            state_reg     <= ST_OPCODE;
            seq_cnt_reg   <= 2'h0;
            erase_req_reg <= 1'b0;
            prog_req_reg  <= 1'b0;
        end else if (lnk.rx_valid) begin
            unique case (state_reg)
                ST_OPCODE: begin
                    seq_cnt_reg <= 2'h1;
                    // Commands arriving during a busy cycle are dropped whole
                    if (busy) begin
                        state_reg <= ST_IGNORE;
                    end else if (lnk.rx_byte == OP_PREFIX0) begin
                        state_reg <= ST_SEQ;
                    end else if (lnk.rx_byte == OP_MAP_READ) begin
                        state_reg <= ST_DUMMY;
                    end else begin
                        state_reg <= ST_IGNORE;
                    end
                end
                ST_SEQ: begin
                    seq_cnt_reg <= seq_cnt_reg + 2'h1;
                    if (seq_cnt_reg == 2'h1) begin
                        state_reg <= (lnk.rx_byte == OP_PREFIX1) ? ST_SEQ : ST_IGNORE;
                    end else if (seq_cnt_reg == 2'h2) begin
                        state_reg <= (lnk.rx_byte == OP_PREFIX2) ? ST_SEQ : ST_IGNORE;
                    // erase taken regardless of global protection
                    end else if (lnk.rx_byte == OP_MAP_ERASE) begin
                        erase_req_reg <= 1'b1;
                        state_reg     <= ST_IGNORE;
                    end else if (lnk.rx_byte == OP_MAP_PROGRAM) begin
                        prog_req_reg <= 1'b1;
                        state_reg    <= ST_PROG_DATA;
                    end else begin
                        state_reg <= ST_IGNORE;
                    end
                end
                ST_DUMMY: begin
                    seq_cnt_reg <= seq_cnt_reg + 2'h1;
                    if (seq_cnt_reg == 2'(DUMMY_BYTES)) begin
                        state_reg <= ST_READ;
                    end
                end
                ST_IGNORE: begin
                    // a further byte after erase opcode cancels it
                    erase_req_reg <= 1'b0;
                end
                ST_READ,
                ST_PROG_DATA: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte n to location n
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wr_ptr_reg   <= '0;
            buf1_wr_en   <= 1'b0;
            buf1_wr_addr <= '0;
            buf1_wr_data <= 8'h00;
        end else begin
            buf1_wr_en <= 1'b0;
            if (state_reg != ST_PROG_DATA) begin
                wr_ptr_reg <= '0;
            end else if (lnk.rx_valid) begin
                stage_reg[wr_ptr_reg] <= lnk.rx_byte;
                buf1_wr_en            <= 1'b1;
                buf1_wr_addr          <= wr_ptr_reg;
                buf1_wr_data          <= lnk.rx_byte;
                wr_ptr_reg            <= wr_ptr_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read pointer advances per byte
    // past the end the fill value goes out
    always_ff @(posedge clk_sys) begin
        if (!resetn || state_reg != ST_READ) begin
            rd_idx_reg <= '0;
        end else if (lnk.tx_load && rd_idx_reg != (SECTOR_W+1)'(MAP_BYTES)) begin
            rd_idx_reg <= rd_idx_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tx_byte_reg <= READ_FILL;
        end else if (rd_idx_reg[SECTOR_W]) begin
            tx_byte_reg <= READ_FILL;
        end else begin
            tx_byte_reg <= map_reg[rd_idx_reg[SECTOR_W-1:0]];
        end
    end

    assign lnk.tx_en   = (state_reg == ST_READ);
    assign lnk.tx_byte = tx_byte_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Self-timed cycles
    assign job_last = job_prog_reg ? TIMER_W'(PROG_CYCLES - 1) : TIMER_W'(ERASE_CYCLES - 1);
    assign job_done = busy && (timer_reg == job_last);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            busy         <= 1'b0;
            job_prog_reg <= 1'b0;
            timer_reg    <= '0;
        end else if (busy) begin
            timer_reg <= timer_reg + 1'b1;
            // erase bounded by its maximum time
            if (job_done) begin
                busy <= 1'b0;
            end
        end else if (lnk.frame_end && wp_clear && (erase_req_reg || prog_req_reg)) begin
            busy         <= 1'b1;
            job_prog_reg <= prog_req_reg;
            timer_reg    <= '0;
        end
    end

    // Program only clears bits, so on a map not erased first it can remove protection but not add it
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int i = 0; i < MAP_BYTES; i++) begin
                map_reg[i] <= MAP_RESET;
            end
        end else if (job_done) begin
            for (int i = 0; i < MAP_BYTES; i++) begin
                // unreceived bytes are ANDed with stale buffer contents
                map_reg[i] <= job_prog_reg ? (map_reg[i] & stage_reg[i]) : MAP_ERASED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lookup gates array commands
    // sector 0 split by bit pairs
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            query_protected <= 1'b0;
        end else begin
            query_protected <= prot_enabled &&
                sector_protected(map_reg[query_sector], query_sector, query_page);
        end
    end

endmodule // sector_protect_map

// ### common/spm_pkg.sv
// Constants, opcodes, timing and state types for the sector protection map block.
// Assumes a single system clock of 125 MHz; serial pins are sampled by that clock.
package spm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Map geometry
    localparam int          MAP_BYTES      = 64;
    localparam int          SECTOR_W       = 6;
    localparam int          PAGE_W         = 7;
    localparam int          SEQ_BYTES      = 4;
    localparam int          DUMMY_BYTES    = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Opcodes
    localparam logic [7:0]  OP_PREFIX0     = 8'h3D;
    localparam logic [7:0]  OP_PREFIX1     = 8'h2A;
    localparam logic [7:0]  OP_PREFIX2     = 8'h7F;
    localparam logic [7:0]  OP_MAP_ERASE   = 8'hCF;
    localparam logic [7:0]  OP_MAP_PROGRAM = 8'hFC;
    localparam logic [7:0]  OP_MAP_READ    = 8'h32;

    ////////////////////////////////////////////////////////////////////////////
    // Values and field positions
    localparam logic [7:0]  MAP_ERASED     = 8'hFF;
    localparam logic [7:0]  MAP_RESET      = 8'h00;
    localparam logic [7:0]  READ_FILL      = 8'h00;
    localparam int          SEC0A_BIT_HI   = 7;
    localparam int          SEC0A_BIT_LO   = 6;
    localparam int          SEC0B_BIT_HI   = 5;
    localparam int          SEC0B_BIT_LO   = 4;
    localparam logic [6:0]  SEC0A_LAST_PG  = 7'h07;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_PERIOD_NS            = 8;
    localparam int          PROTECT_ERASE_TIME_MAX_NS = 50000;
    localparam int          PROGRAM_TIME_MAX_NS      = 40000;
    // Longest times round down to whole cycles
    localparam int          ERASE_CYCLES_DEF = PROTECT_ERASE_TIME_MAX_NS / CLK_PERIOD_NS;
    localparam int          PROG_CYCLES_DEF  = PROGRAM_TIME_MAX_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Frame decoder states
    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_SEQ,
        ST_DUMMY,
        ST_READ,
        ST_PROG_DATA,
        ST_IGNORE
    } frame_state_t;

    // Protection of one page given its map byte
    function automatic logic sector_protected(input logic [7:0] map_byte,
                                              input logic [5:0] sector,
                                              input logic [6:0] page);
        logic res;
        res = 1'b0;
        if (sector != 6'h00) begin
            res = (map_byte == MAP_ERASED);
        end else if (page <= SEC0A_LAST_PG) begin
            res = map_byte[SEC0A_BIT_HI] & map_byte[SEC0A_BIT_LO];
        end else begin
            res = map_byte[SEC0B_BIT_HI] & map_byte[SEC0B_BIT_LO];
        end
        return res;
    endfunction

endpackage

// ### common/spi_byte_if.sv
// Byte-level link between the serial front end and the map command core.
// Both ends run on clk_sys.
`timescale 1ns/1ps
interface spi_byte_if;
    logic       frame_active;
    logic       frame_end;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       tx_en;
    logic [7:0] tx_byte;
    logic       tx_load;

    modport front (
        output frame_active,
        output frame_end,
        output rx_valid,
        output rx_byte,
        output tx_load,
        input  tx_en,
        input  tx_byte
    );

    modport core (
        input  frame_active,
        input  frame_end,
        input  rx_valid,
        input  rx_byte,
        input  tx_load,
        output tx_en,
        output tx_byte
    );
endinterface

// ### verilog/spi_link_frontend.sv
// Serial front end: synchronises the select, clock and data pins, assembles bytes
// on rising clock edges and shifts reply bytes out on falling edges, MSB first.
// Assumes the serial clock is far slower than clk_sys (at least four samples a phase).
`timescale 1ns/1ps
module spi_link_frontend
    import spm_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      resetn,
    input  wire logic      cs_n,
    input  wire logic      sck,
    input  wire logic      si,
    output logic           so_out,
    output logic           so_oe,
    spi_byte_if.front      lnk
);

    logic [1:0] cs_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] si_sync_reg;
    logic       sck_last_reg;
    logic       active_last_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic       rx_valid_reg;
    logic [7:0] rx_byte_reg;
    logic       frame_end_reg;
    logic [7:0] tx_shift_reg;
    logic       tx_load_reg;
    logic       active;
    logic       sck_rise;
    logic       sck_fall;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cs_sync_reg  <= 2'h3;
            sck_sync_reg <= 2'h0;
            si_sync_reg  <= 2'h0;
            sck_last_reg <= 1'b0;
            active_last_reg <= 1'b0;
        end else begin
            cs_sync_reg  <= {cs_sync_reg[0], cs_n};
            sck_sync_reg <= {sck_sync_reg[0], sck};
            si_sync_reg  <= {si_sync_reg[0], si};
            sck_last_reg <= sck_sync_reg[1];
            active_last_reg <= active;
        end
    end

    assign active   = ~cs_sync_reg[1];
    assign sck_rise = sck_sync_reg[1] & ~sck_last_reg;
    assign sck_fall = ~sck_sync_reg[1] & sck_last_reg;

    ////////////////////////////////////////////////////////////////////////////
    // MSB first, sample on rise
    always_ff @(posedge clk_sys) begin
        if (!resetn || !active) begin
            bit_cnt_reg  <= 3'h0;
            shift_reg    <= 7'h00;
            rx_valid_reg <= 1'b0;
            rx_byte_reg  <= 8'h00;
        end else begin
            rx_valid_reg <= sck_rise && (bit_cnt_reg == 3'h7);
            if (sck_rise) begin
                shift_reg   <= {shift_reg[5:0], si_sync_reg[1]};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    rx_byte_reg <= {shift_reg, si_sync_reg[1]};
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            frame_end_reg <= 1'b0;
        end else begin
            frame_end_reg <= active_last_reg & ~active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output changes on falling edge
    // high impedance once select is removed
    always_ff @(posedge clk_sys) begin
        if (!resetn || !active) begin
            so_out       <= 1'b0;
            so_oe        <= 1'b0;
            tx_shift_reg <= 8'h00;
            tx_load_reg  <= 1'b0;
        end else begin
            tx_load_reg <= 1'b0;
            if (sck_fall && lnk.tx_en) begin
                so_oe <= 1'b1;
                if (bit_cnt_reg == 3'h0) begin
                    so_out       <= lnk.tx_byte[7];
                    tx_shift_reg <= {lnk.tx_byte[6:0], 1'b0};
                    tx_load_reg  <= 1'b1;
                end else begin
                    so_out       <= tx_shift_reg[7];
                    tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                end
            end
        end
    end

    assign lnk.frame_active = active;
    assign lnk.frame_end    = frame_end_reg;
    assign lnk.rx_valid     = rx_valid_reg;
    assign lnk.rx_byte      = rx_byte_reg;
    assign lnk.tx_load      = tx_load_reg;

endmodule // spi_link_frontend

// ### sim/spm_monitor.sv
// Concurrent checks on the sector protection map top ports.
// Assumes one clk_sys domain; bound to every instance of the top.
`timescale 1ns/1ps
module spm_monitor
    import spm_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
    parameter int PROG_CYCLES  = PROG_CYCLES_DEF
) (
    input wire logic                clk_sys,
    input wire logic                resetn,
    input wire logic                cs_n,
    input wire logic                wp_n,
    input wire logic                prot_enabled,
    input wire logic                so_oe,
    input wire logic                busy,
    input wire logic                query_protected,
    input wire logic                buf1_wr_en,
    input wire logic [SECTOR_W-1:0] buf1_wr_addr
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0]         busy_cnt_reg;
    logic [SECTOR_W-1:0] last_addr_reg;
    logic                wr_seen_reg;

    always_ff @(posedge clk_sys) begin
        if (!resetn || !busy) begin
            busy_cnt_reg <= 16'h0000;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 16'h0001;
        end
    end

    // Pointer history is per frame, so a new select restarts it
    always_ff @(posedge clk_sys) begin
        if (!resetn || cs_n) begin
            wr_seen_reg <= 1'b0;
        end else if (buf1_wr_en) begin
            wr_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (buf1_wr_en) begin
            last_addr_reg <= buf1_wr_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_busy_launch: assert property ($rose(busy) |-> $past(cs_n, 3) && wp_n)
        else $error("busy rose without a closed frame");
    a_busy_length: assert property ($fell(busy) |->
        busy_cnt_reg == ERASE_CYCLES || busy_cnt_reg == PROG_CYCLES)
        else $error("busy length wrong");
    a_oe_idle: assert property (cs_n [*6] |-> !so_oe)
        else $error("output driven while deselected");
    a_oe_start: assert property ($rose(so_oe) |-> !cs_n && !busy)
        else $error("output enabled outside a read");
    a_wr_pulse: assert property (buf1_wr_en |=> !buf1_wr_en)
        else $error("buffer write longer than one cycle");
    a_wr_frame: assert property (buf1_wr_en |-> !cs_n && !busy)
        else $error("buffer write outside a frame");
    a_wr_first: assert property (buf1_wr_en && !wr_seen_reg |-> buf1_wr_addr == '0)
        else $error("first map byte not at location 0");
    a_wr_wrap: assert property (buf1_wr_en && wr_seen_reg |->
        buf1_wr_addr == last_addr_reg + 1'b1)
        else $error("write pointer did not step");
    a_query_off: assert property (!prot_enabled |=> !query_protected)
        else $error("protected while protection off");

    c_busy: cover property ($rose(busy));
    c_read: cover property ($rose(so_oe));
    c_wrap: cover property (buf1_wr_en && buf1_wr_addr == '1);
    c_prot: cover property (query_protected);
endmodule // spm_monitor

bind sector_protect_map spm_monitor #(
    .ERASE_CYCLES (ERASE_CYCLES),
    .PROG_CYCLES  (PROG_CYCLES)
) u_spm_monitor (
    .clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .wp_n(wp_n),
    .prot_enabled(prot_enabled), .so_oe(so_oe), .busy(busy),
    .query_protected(query_protected), .buf1_wr_en(buf1_wr_en),
    .buf1_wr_addr(buf1_wr_addr)
);

// ### sim/spi_host_model.sv
// Host controller model: drives select, serial clock and data in mode 0.
// Assumes clk_sys is the bench clock; the serial clock stands low between frames.
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic clk_sys,
    input  wire logic so_out,
    output logic      cs_n,
    output logic      sck,
    output logic      si
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // Half of the 160 ns serial clock period
    task automatic half_bit();
        repeat (10) @(negedge clk_sys);
    endtask

    task automatic select_dev();
        @(negedge clk_sys);
        cs_n = 1'b0;
        half_bit();
    endtask

    task automatic clock_bit(input logic b, output logic s);
        si = b;
        half_bit();
        sck = 1'b1;
        s = so_out;
        half_bit();
        sck = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(tx[i], s);
            rx[i] = s;
        end
    endtask

    task automatic release_dev();
        half_bit();
        cs_n = 1'b1;
        si   = ~si;  // A released line shows no stale level
        repeat (6) @(negedge clk_sys);
    endtask
endmodule // spi_host_model

// ### sim/sector_protect_map_tb_top.sv
// Self-checking bench for the sector protection map command core.
// Assumes the host model drives the serial pins; busy counts are shortened.
`timescale 1ns/1ps
module sector_protect_map_tb_top
    import spm_pkg::*;
;
    localparam int ERASE_N = 20;
    localparam int PROG_N  = 16;

    logic                clk_sys = 1'b0;
    logic                resetn;
    logic                wp_n;
    logic                prot_enabled;
    logic [SECTOR_W-1:0] query_sector;
    logic [PAGE_W-1:0]   query_page;
    wire                 cs_n;
    wire                 sck;
    wire                 si;
    wire                 so_out;
    wire                 so_oe;
    wire                 busy;
    wire                 query_protected;
    wire                 buf1_wr_en;
    wire [SECTOR_W-1:0]  buf1_wr_addr;
    wire [7:0]           buf1_wr_data;
    int                  num_errors = 0;
    int                  compares   = 0;
    int                  runs       = 0;
    int                  run_len    = 0;
    int                  run_cnt    = 0;
    int                  wr_count   = 0;
    logic [7:0]          map_exp [MAP_BYTES];
    logic [7:0]          stage   [MAP_BYTES];
    logic [7:0]          rd      [MAP_BYTES];

    always #4 clk_sys = ~clk_sys;
    sector_protect_map #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
        .wp_n(wp_n), .prot_enabled(prot_enabled), .query_sector(query_sector),
        .query_page(query_page), .so_out(so_out), .so_oe(so_oe), .busy(busy),
        .query_protected(query_protected), .buf1_wr_en(buf1_wr_en),
        .buf1_wr_addr(buf1_wr_addr), .buf1_wr_data(buf1_wr_data)
    );

    spi_host_model host (.clk_sys(clk_sys), .so_out(so_out), .cs_n(cs_n), .sck(sck), .si(si));

    ////////////////////////////////////////////////////////////////////////////
    // Busy runs and buffer writes are logged as they happen
    always @(posedge clk_sys) begin
        if (busy === 1'b1) begin
            run_cnt = run_cnt + 1;
        end else if (run_cnt != 0) begin
            run_len = run_cnt;
            runs    = runs + 1;
            run_cnt = 0;
        end
        if (buf1_wr_en === 1'b1) begin
            stage[buf1_wr_addr] = buf1_wr_data;
            wr_count = wr_count + 1;
        end
    end

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_sys);
        if (busy !== 1'b0) num_errors++;
        @(negedge clk_sys);
    endtask

    task automatic send_op(input logic [7:0] op);
        logic [7:0] rx;
        host.select_dev();
        host.xfer(OP_PREFIX0, rx);
        host.xfer(OP_PREFIX1, rx);
        host.xfer(OP_PREFIX2, rx);
        host.xfer(op, rx);
    endtask

    task automatic read_map(input int n);
        logic [7:0] rx;
        host.select_dev();
        host.xfer(OP_MAP_READ, rx);
        for (int i = 0; i < DUMMY_BYTES; i++) host.xfer(8'hA5, rx);
        for (int i = 0; i < n; i++) begin
            host.xfer(8'h5A, rx);
            rd[i] = rx;
        end
        check_bit(so_oe, 1'b1);
        host.release_dev();
        check_bit(so_oe, 1'b0);
    endtask

    task automatic query(input logic [5:0] sec, input logic [6:0] pg, input logic exp);
        query_sector = sec;
        query_page   = pg;
        repeat (2) @(negedge clk_sys);
        check_bit(query_protected, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_read();
        read_map(8);
        for (int i = 0; i < 8; i++) check_byte(rd[i], MAP_RESET);
    endtask

    task automatic t_erase();
        int r0;
        r0 = runs;
        prot_enabled = 1'b0;
        send_op(OP_MAP_ERASE);
        host.release_dev();
        wait_idle();
        check_byte(8'(runs - r0), 8'h01);
        check_byte(8'(run_len), 8'(ERASE_N));
        read_map(MAP_BYTES);
        for (int i = 0; i < MAP_BYTES; i++) check_byte(rd[i], 8'hFF);
        prot_enabled = 1'b1;
        query(6'h09, 7'h00, 1'b1);
    endtask

    task automatic t_program();
        logic [7:0] rx;
        int         w0;
        // only 00 and FF above location 0
        for (int i = 0; i < MAP_BYTES; i++) map_exp[i] = (i % 3 == 0) ? 8'hFF : 8'h00;
        w0 = wr_count;
        send_op(OP_MAP_PROGRAM);
        for (int k = 0; k < MAP_BYTES; k++) host.xfer(map_exp[k], rx);
        host.xfer(8'hC0, rx);
        host.release_dev();
        wait_idle();
        map_exp[0] = 8'hC0;
        check_byte(8'(wr_count - w0), 8'h41);
        check_byte(stage[0], 8'hC0);
        check_byte(8'(run_len), 8'(PROG_N));
        read_map(MAP_BYTES);
        for (int i = 0; i < MAP_BYTES; i++) check_byte(rd[i], map_exp[i]);
        query(6'h00, 7'h07, 1'b1);
        query(6'h00, 7'h08, 1'b0);
        query(6'h03, 7'h00, 1'b1);
        query(6'h04, 7'h00, 1'b0);
    endtask

    task automatic t_refuse();
        int         r0;
        logic [7:0] rb;
        r0 = runs;
        wp_n = 1'b0;
        send_op(OP_MAP_ERASE);
        host.release_dev();
        wp_n = 1'b1;
        send_op(OP_MAP_ERASE);
        host.xfer(8'h00, rb);
        host.release_dev();
        wait_idle();
        check_byte(8'(runs - r0), 8'h00);
        read_map(4);
        for (int i = 0; i < 4; i++) check_byte(rd[i], map_exp[i]);
        prot_enabled = 1'b0;
        query(6'h03, 7'h00, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn       = 1'b0;
        wp_n         = 1'b1;
        prot_enabled = 1'b0;
        query_sector = '0;
        query_page   = '0;
        repeat (8) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_reset_read();
        t_erase();
        t_program();
        t_refuse();
        complete_run();
    end

    // Whole run needs about 40000 cycles
    initial begin
        repeat (80000) @(posedge clk_sys);
        num_errors = num_errors + 1;
        complete_run();
    end
endmodule // sector_protect_map_tb_top
